// ===== design/timing_unit.sv
// Watchdog timer, general timer and event counter with an APB register slave.
//
// Notes on behaviour
// RQ1: Watchdog timer is 12 bits, counts down from reload, may interrupt at timeout.
// RQ2: Watchdog count, status and interrupt registers are readable at any time.
// RQ3: In watchdog mode a timeout switches off all digital outputs.
// RQ4: While watchdog runs, each write of the outputs reloads its count; the code reloads only in watchdog mode.
// RQ5: A software trigger command reloads the watchdog without touching outputs.
// RQ6: Software selects one of three time bases for the watchdog.
// RQ7: Running, stopped and timed-out state of the watchdog are readable.
// RQ8: General timer is 12 bits, counts down, may interrupt at run down.
// RQ9: General timer count, status and interrupt registers are readable.
// RQ10: Event counter is 16 bits, clocked by input 0, which stays readable.
// RQ11: Event counter has no gate or trigger pin; only software clears or triggers.
// RQ12: Event counter follows input events up to 100 KHz.
// RQ13: Software picks rising, falling or both edges as counting edges.
// RQ14: Software picks up or down counting.
// RQ15: A 16-bit software reload value sets the counting period.
// RQ16: Up mode counts from zero; at reload minus one next edge gives zero.
// RQ17: Down mode counts from reload; at zero next edge loads reload.
// RQ18: A wrap in either direction raises an interrupt when enabled.
// RQ19: Clear sets the counter to zero; in up mode trigger does too.
// RQ20: In down mode trigger loads the reload value.
// RQ21: Four interrupt sources are kept apart on one interrupt line.
// RQ22: Output reset, at power-on or watchdog timeout, turns every channel off; a timeout clears the outputs only in watchdog mode.
// RQ23: Timers and counter run only after start; stop holds the value.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps

// ==========================================================
// Down timer shared by watchdog and general timer
module down_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tick,
   input  wire logic        start,
   input  wire logic        stop,
   input  wire logic        trig,
   input  wire logic        one_shot,
   input  wire logic [11:0] reload,
   output logic      [11:0] count,
   output logic             running,
   output logic             expired
);
   wire hit = running & tick & (count <= 12'h001);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= 12'h000;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= hit & ~start & ~stop & ~trig;
         if (start) begin // [RQ23]
            count   <= reload;
            running <= 1'b1;
         end else if (stop) begin // [RQ23]
            running <= 1'b0;
         end else if (trig) begin // [RQ5]
            count <= reload;
         end else if (hit) begin // [RQ1] [RQ8]
            count   <= reload;
            running <= ~one_shot;
         end else if (running & tick) begin
            count <= count - 12'h001;
         end
      end
   end
endmodule // down_timer

// ==========================================================
// Top level
module timing_unit (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        input_ch0,
   output logic      [15:0] digital_out,
   output logic             irq
);
   // ==========================================================
   // Registers
   logic [11:0] wd_reload_reg;
   logic [3:0]  wd_ctrl_reg;
   logic [11:0] gt_reload_reg;
   logic [3:0]  gt_ctrl_reg;
   logic [15:0] ec_reload_reg;
   logic [3:0]  ec_ctrl_reg;
   logic [15:0] ec_count_reg;
   logic [15:0] ec_count_next;
   logic        ec_run_reg;
   logic        ec_wrap_reg;
   logic        ch0_prev_reg;
   logic        wd_tmo_reg;
   logic        wd_shut_reg;
   logic [3:0]  irq_reg;
   logic [3:0]  irq_next;
   logic [5:0]  us_cnt_reg;
   logic [9:0]  ms_cnt_reg;
   logic [9:0]  s_cnt_reg;
   logic        us_tick_reg;
   logic        ms_tick_reg;
   logic        s_tick_reg;
   logic [11:0] wd_count;
   logic [11:0] gt_count;
   logic        wd_run;
   logic        gt_run;
   logic        wd_exp;
   logic        gt_exp;

   // ==========================================================
   // Bus decode
   wire setup  = psel & ~penable;
   wire wr_en  = psel & penable & pwrite & pready;
   wire wr_wdr = wr_en & (paddr == timing_unit_pkg::WD_RELOAD_OFS);
   wire wr_wdc = wr_en & (paddr == timing_unit_pkg::WD_CTRL_OFS);
   wire wr_irq = wr_en & (paddr == timing_unit_pkg::IRQ_OFS);
   wire wr_gtr = wr_en & (paddr == timing_unit_pkg::GT_RELOAD_OFS);
   wire wr_gtc = wr_en & (paddr == timing_unit_pkg::GT_CTRL_OFS);
   wire wr_ecr = wr_en & (paddr == timing_unit_pkg::EC_RELOAD_OFS);
   wire wr_ecc = wr_en & (paddr == timing_unit_pkg::EC_CTRL_OFS);
   wire wr_cmd = wr_en & (paddr == timing_unit_pkg::CMD_OFS);
   wire wr_out = wr_en & (paddr == timing_unit_pkg::DOUT_OFS);
   wire [9:0] cmd = wr_cmd ? pwdata[9:0] : 10'h000;
   wire mapped = (paddr[1:0] == 2'h0) && (paddr <= timing_unit_pkg::DOUT_OFS);

   wire [31:0] status_word = {26'h0000000, input_ch0, wd_shut_reg, ec_run_reg,
                              gt_run, wd_tmo_reg, wd_run}; // [RQ7] [RQ10]
   wire [31:0] rd_data =
      (paddr == timing_unit_pkg::WD_RELOAD_OFS) ? {20'h00000, wd_reload_reg} :
      (paddr == timing_unit_pkg::WD_CTRL_OFS)   ? {28'h0000000, wd_ctrl_reg} :
      (paddr == timing_unit_pkg::WD_COUNT_OFS)  ? {20'h00000, wd_count} : // [RQ2]
      (paddr == timing_unit_pkg::STATUS_OFS)    ? status_word :
      (paddr == timing_unit_pkg::IRQ_OFS)       ? {28'h0000000, irq_reg} :
      (paddr == timing_unit_pkg::GT_RELOAD_OFS) ? {20'h00000, gt_reload_reg} :
      (paddr == timing_unit_pkg::GT_CTRL_OFS)   ? {28'h0000000, gt_ctrl_reg} :
      (paddr == timing_unit_pkg::GT_COUNT_OFS)  ? {20'h00000, gt_count} : // [RQ9]
      (paddr == timing_unit_pkg::EC_RELOAD_OFS) ? {16'h0000, ec_reload_reg} :
      (paddr == timing_unit_pkg::EC_CTRL_OFS)   ? {28'h0000000, ec_ctrl_reg} :
      (paddr == timing_unit_pkg::EC_COUNT_OFS)  ? {16'h0000, ec_count_reg} :
      (paddr == timing_unit_pkg::DOUT_OFS)      ? {16'h0000, digital_out} :
      32'h00000000;

   // Read data is captured in the setup cycle, so every access ends with
   // no wait state and the outputs stay straight from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_data : 32'h00000000;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_reload_reg <= timing_unit_pkg::TMR_RELOAD_RST;
         gt_reload_reg <= timing_unit_pkg::TMR_RELOAD_RST;
         ec_reload_reg <= timing_unit_pkg::EC_RELOAD_RST;
         wd_ctrl_reg   <= 4'h0;
         gt_ctrl_reg   <= 4'h0;
         ec_ctrl_reg   <= 4'h1;
      end else begin
         if (wr_wdr) wd_reload_reg <= pwdata[11:0];
         if (wr_gtr) gt_reload_reg <= pwdata[11:0];
         if (wr_ecr) ec_reload_reg <= pwdata[15:0]; // [RQ15]
         if (wr_wdc) wd_ctrl_reg <= pwdata[3:0];
         if (wr_gtc) gt_ctrl_reg <= pwdata[3:0];
         if (wr_ecc) ec_ctrl_reg <= pwdata[3:0];
      end
   end

   // ==========================================================
   // Time bases of 1 us, 1 ms and 1 s, chained so no counter is long
   wire us_last = us_cnt_reg == 6'(timing_unit_pkg::TICK_US_CYCLES - 1);
   wire ms_last = ms_cnt_reg == 10'(timing_unit_pkg::DECADE_STEPS - 1);
   wire s_last  = s_cnt_reg == 10'(timing_unit_pkg::DECADE_STEPS - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         us_cnt_reg  <= 6'h00;
         ms_cnt_reg  <= 10'h000;
         s_cnt_reg   <= 10'h000;
         us_tick_reg <= 1'b0;
         ms_tick_reg <= 1'b0;
         s_tick_reg  <= 1'b0;
      end else begin
         us_tick_reg <= us_last;
         us_cnt_reg  <= us_last ? 6'h00 : us_cnt_reg + 6'h01;
         ms_tick_reg <= us_tick_reg & ms_last;
         s_tick_reg  <= ms_tick_reg & s_last;
         if (us_tick_reg) ms_cnt_reg <= ms_last ? 10'h000 : ms_cnt_reg + 10'h001;
         if (ms_tick_reg) s_cnt_reg <= s_last ? 10'h000 : s_cnt_reg + 10'h001;
      end
   end

   function automatic logic base_sel(input logic [1:0] sel, input logic us,
                                     input logic ms, input logic s);
      base_sel = (sel == timing_unit_pkg::SEL_US) ? us :
                 (sel == timing_unit_pkg::SEL_MS) ? ms : s;
   endfunction

   // ==========================================================
   // Watchdog and general timer
   wire wd_mode = wd_ctrl_reg[timing_unit_pkg::WD_MODE_BIT];
   wire wd_tick = base_sel(wd_ctrl_reg[2:1], us_tick_reg, ms_tick_reg,
                           s_tick_reg); // [RQ6]
   wire gt_tick = base_sel(gt_ctrl_reg[2:1], us_tick_reg, ms_tick_reg, s_tick_reg);
   wire wd_retrig = cmd[timing_unit_pkg::CMD_WD_TRIG] |
                    (wr_out & wd_mode & wd_run); // [RQ4] [RQ5]

   down_timer u_wd (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (wd_tick),
      .start    (cmd[timing_unit_pkg::CMD_WD_START]),
      .stop     (cmd[timing_unit_pkg::CMD_WD_STOP]),
      .trig     (wd_retrig),
      .one_shot (wd_mode),
      .reload   (wd_reload_reg),
      .count    (wd_count),
      .running  (wd_run),
      .expired  (wd_exp)
   );

   down_timer u_gt (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (gt_tick),
      .start    (cmd[timing_unit_pkg::CMD_GT_START]),
      .stop     (cmd[timing_unit_pkg::CMD_GT_STOP]),
      .trig     (cmd[timing_unit_pkg::CMD_GT_TRIG]),
      .one_shot (1'b0),
      .reload   (gt_reload_reg),
      .count    (gt_count),
      .running  (gt_run),
      .expired  (gt_exp)
   );

   // Timeout state stays until the next start, so software can poll it late.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_tmo_reg  <= 1'b0;
         wd_shut_reg <= 1'b0;
      end else begin
         if (wd_exp) begin // [RQ7]
            wd_tmo_reg  <= 1'b1;
            wd_shut_reg <= wd_mode;
         end else if (cmd[timing_unit_pkg::CMD_WD_START]) begin
            wd_tmo_reg  <= 1'b0;
            wd_shut_reg <= 1'b0;
         end
      end
   end

   // A watchdog-mode timeout beats a write in the same cycle: the outputs go off.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         digital_out <= 16'h0000; // [RQ22]
      end else if (wd_exp & wd_mode) begin
         digital_out <= 16'h0000; // [RQ3] [RQ22]
      end else if (wr_out) begin
         digital_out <= pwdata[15:0];
      end
   end

   // ==========================================================
   // Event counter on input 0; only software commands clear or trigger it
   wire ec_down  = ec_ctrl_reg[timing_unit_pkg::EC_DOWN_BIT]; // [RQ14]
   wire ch0_rise = input_ch0 & ~ch0_prev_reg;
   wire ch0_fall = ~input_ch0 & ch0_prev_reg;
   wire ec_edge  = (ec_ctrl_reg[0] & ch0_rise) | (ec_ctrl_reg[1] & ch0_fall); // [RQ13]
   wire ec_step  = ec_run_reg & ec_edge; // [RQ12]
   wire ec_top   = ec_count_reg == (ec_reload_reg - 16'h0001);
   wire ec_zero  = ec_count_reg == 16'h0000;
   wire ec_wrap  = ec_step & (ec_down ? ec_zero : ec_top);
   wire ec_clr   = cmd[timing_unit_pkg::CMD_EC_CLEAR];
   wire ec_trg   = cmd[timing_unit_pkg::CMD_EC_TRIG] |
                   cmd[timing_unit_pkg::CMD_EC_START]; // [RQ11]
   wire [15:0] ec_start_val = ec_down ? ec_reload_reg : 16'h0000;

   assign ec_count_next =
      ec_clr  ? 16'h0000 : // [RQ19]
      ec_trg  ? ec_start_val : // [RQ19] [RQ20]
      ec_wrap ? ec_start_val : // [RQ16] [RQ17]
      ec_step ? (ec_down ? ec_count_reg - 16'h0001 : ec_count_reg + 16'h0001) :
      ec_count_reg; // [RQ23]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ec_count_reg <= 16'h0000;
         ec_run_reg   <= 1'b0;
         ec_wrap_reg  <= 1'b0;
         ch0_prev_reg <= 1'b0;
      end else begin
         ch0_prev_reg <= input_ch0;
         ec_count_reg <= ec_count_next; // [RQ10]
         ec_wrap_reg  <= ec_wrap & ~ec_clr & ~ec_trg;
         if (cmd[timing_unit_pkg::CMD_EC_START]) ec_run_reg <= 1'b1; // [RQ23]
         else if (cmd[timing_unit_pkg::CMD_EC_STOP]) ec_run_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt sources, write one to clear; a new event wins over the clear
   wire [3:0] irq_set = {wd_exp & wd_mode, ec_wrap_reg, gt_exp, wd_exp}; // [RQ21]
   wire [3:0] irq_en  = {wd_ctrl_reg[3], ec_ctrl_reg[3], gt_ctrl_reg[3],
                         wd_ctrl_reg[3]};
   assign irq_next = (irq_reg & ~(wr_irq ? pwdata[3:0] : 4'h0)) | irq_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 4'h0;
         irq     <= 1'b0;
      end else begin
         irq_reg <= irq_next; // [RQ21]
         irq     <= |(irq_reg & irq_en); // [RQ1] [RQ8] [RQ18]
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_shutdown;
      wd_exp & wd_mode |=> digital_out == 16'h0000 && irq_reg[3];
   endproperty
   a_shutdown: assert property (p_shutdown) // [RQ3]
      else $error("watchdog timeout did not switch outputs off");

   property p_out_retrigger;
      wr_out & wd_mode & wd_run & ~cmd[0] & ~cmd[1] |=> wd_count == $past(wd_reload_reg);
   endproperty
   a_out_retrigger: assert property (p_out_retrigger) // [RQ4]
      else $error("output write did not reload watchdog");

   property p_soft_trigger;
      cmd[2] & ~cmd[0] & ~cmd[1] & ~wr_out & ~wd_exp |=> wd_count == $past(wd_reload_reg)
         && $stable(digital_out);
   endproperty
   a_soft_trigger: assert property (p_soft_trigger) // [RQ5]
      else $error("trigger command misbehaved");

   property p_up_wrap;
      ec_step & ~ec_down & ec_top & ~ec_clr & ~ec_trg |=> ec_count_reg == 16'h0000
         ##1 irq_reg[2];
   endproperty
   a_up_wrap: assert property (p_up_wrap) // [RQ16]
      else $error("up counter did not wrap to zero");

   property p_down_wrap;
      ec_step & ec_down & ec_zero & ~ec_clr & ~ec_trg |=>
         ec_count_reg == $past(ec_reload_reg);
   endproperty
   a_down_wrap: assert property (p_down_wrap) // [RQ17]
      else $error("down counter did not reload at zero");

   property p_wrap_irq;
      ec_wrap & ~ec_clr & ~ec_trg |-> ##2 irq_reg[2];
   endproperty
   a_wrap_irq: assert property (p_wrap_irq) // [RQ18]
      else $error("counter wrap not flagged");

   property p_clear;
      ec_clr |=> ec_count_reg == 16'h0000;
   endproperty
   a_clear: assert property (p_clear) // [RQ19]
      else $error("clear did not zero the counter");

   property p_down_trigger;
      cmd[9] & ~ec_clr & ec_down |=> ec_count_reg == $past(ec_reload_reg);
   endproperty
   a_down_trigger: assert property (p_down_trigger) // [RQ20]
      else $error("down trigger did not load reload");

   property p_hold;
      ~ec_run_reg & ~ec_clr & ~ec_trg |=> $stable(ec_count_reg);
   endproperty
   a_hold: assert property (p_hold) // [RQ23]
      else $error("stopped counter changed");

   property p_wd_tick_sel;
      wd_run & ~wd_tick & ~wd_retrig & ~cmd[0] & ~cmd[1] |=> $stable(wd_count);
   endproperty
   a_wd_tick_sel: assert property (p_wd_tick_sel) // [RQ6]
      else $error("watchdog counted without a time base tick");
endmodule // timing_unit

// ===== design/timing_unit_pkg.sv
// Package with register map, field layout and timing constants of the timing unit.
package timing_unit_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] WD_RELOAD_OFS = 8'h00;
   localparam logic [7:0] WD_CTRL_OFS   = 8'h04;
   localparam logic [7:0] WD_COUNT_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS    = 8'h0C;
   localparam logic [7:0] IRQ_OFS       = 8'h10;
   localparam logic [7:0] GT_RELOAD_OFS = 8'h14;
   localparam logic [7:0] GT_CTRL_OFS   = 8'h18;
   localparam logic [7:0] GT_COUNT_OFS  = 8'h1C;
   localparam logic [7:0] EC_RELOAD_OFS = 8'h20;
   localparam logic [7:0] EC_CTRL_OFS   = 8'h24;
   localparam logic [7:0] EC_COUNT_OFS  = 8'h28;
   localparam logic [7:0] CMD_OFS       = 8'h2C;
   localparam logic [7:0] DOUT_OFS      = 8'h30;
   // ==========================================================
   // Widths and reset values
   localparam int TMR_W = 12;
   localparam int EC_W  = 16;
   localparam int OUT_W = 16;
   localparam logic [11:0] TMR_RELOAD_RST = 12'hFFF;
   localparam logic [15:0] EC_RELOAD_RST  = 16'hFFFF;
   // ==========================================================
   // Field positions
   localparam int WD_MODE_BIT  = 0;
   localparam int CLK_SEL_LO   = 1;
   localparam int TMR_IRQE_BIT = 3;
   localparam int EC_EDGE_LO   = 0;
   localparam int EC_DOWN_BIT  = 2;
   localparam int EC_IRQE_BIT  = 3;
   localparam int CMD_WD_START = 0;
   localparam int CMD_WD_STOP  = 1;
   localparam int CMD_WD_TRIG  = 2;
   localparam int CMD_GT_START = 3;
   localparam int CMD_GT_STOP  = 4;
   localparam int CMD_GT_TRIG  = 5;
   localparam int CMD_EC_START = 6;
   localparam int CMD_EC_STOP  = 7;
   localparam int CMD_EC_CLEAR = 8;
   localparam int CMD_EC_TRIG  = 9;
   localparam int IRQ_WD_TMO   = 0;
   localparam int IRQ_GT_TMO   = 1;
   localparam int IRQ_EC_WRAP  = 2;
   localparam int IRQ_WD_SHUT  = 3;
   localparam int IRQ_N        = 4;
   // ==========================================================
   // Time bases
   localparam int CLK_PERIOD_NS  = 25;
   localparam int TICK_US_NS     = 1000;
   localparam int TICK_US_CYCLES = TICK_US_NS / CLK_PERIOD_NS;
   localparam int DECADE_STEPS   = 1000;
   localparam logic [1:0] SEL_US = 2'h0;
   localparam logic [1:0] SEL_MS = 2'h1;
endpackage

// ===== tb/apb_host.sv
// APB host model that plays the software side of the timing unit.
`timescale 1ns/10ps

module apb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end

   // ==========================================================
   // One bus transfer
   // The request stays put until pready is seen high, since the slave sets the pace.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // apb_host

// ===== tb/timing_unit_bench.sv
// Self-checking bench for the timing unit, driven through its register bus.
`timescale 1ns/10ps

module timing_unit_bench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        input_ch0;
   logic [15:0] digital_out;
   logic        irq;
   logic [31:0] q;
   logic        e;
   int          fails;
   int          cmp_count;

   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   timing_unit u_timing_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .input_ch0(input_ch0), .digital_out(digital_out), .irq(irq));

   apb_host u_apb_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // ==========================================================
   // Access and compare tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        x;
      u_apb_host.xfer(1'b1, a, d, r, x);
   endtask

   task automatic cmd(input logic [31:0] d);
      wr(timing_unit_pkg::CMD_OFS, d);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] r;
      logic        x;
      u_apb_host.xfer(1'b0, a, 32'h00000000, r, x);
      chk(r & m, exp);
   endtask

   // Each toggle is one edge on the counter input; four cycles let the edge detector settle.
   task automatic tog(input int n);
      repeat (n) begin
         input_ch0 <= ~input_ch0;
         repeat (4) @(posedge pclk);
      end
   endtask

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      summarize();
   end

   // ==========================================================
   // Test sequence
   initial begin
      fails = 0;
      cmp_count = 0;
      presetn = 1'b0;
      input_ch0 = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rchk(timing_unit_pkg::WD_RELOAD_OFS, 32'hFFFFFFFF, 32'h00000FFF);
      rchk(timing_unit_pkg::EC_RELOAD_OFS, 32'hFFFFFFFF, 32'h0000FFFF);
      rchk(timing_unit_pkg::STATUS_OFS, 32'hFFFFFFFF, 32'h00000000);
      rchk(timing_unit_pkg::CMD_OFS, 32'hFFFFFFFF, 32'h00000000);
      chk({16'h0000, digital_out}, 32'h00000000);
      u_apb_host.xfer(1'b0, 8'h34, 32'h00000000, q, e);
      chk({31'h00000000, e}, 32'h00000001);
      // Watchdog: reload 5 at the 1us base expires 161 to 200 cycles after a reload.
      wr(timing_unit_pkg::WD_RELOAD_OFS, 32'h00000005);
      wr(timing_unit_pkg::WD_CTRL_OFS, 32'h00000009);
      wr(timing_unit_pkg::DOUT_OFS, 32'h0000FFFF);
      cmd(32'h00000001);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000003, 32'h00000001);
      repeat (100) @(posedge pclk);
      wr(timing_unit_pkg::DOUT_OFS, 32'h000000FF);
      repeat (100) @(posedge pclk);
      chk({16'h0000, digital_out}, 32'h000000FF);
      cmd(32'h00000004);
      repeat (100) @(posedge pclk);
      chk({16'h0000, digital_out}, 32'h000000FF);
      repeat (150) @(posedge pclk);
      chk({16'h0000, digital_out}, 32'h00000000);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000013, 32'h00000012);
      rchk(timing_unit_pkg::IRQ_OFS, 32'h0000000F, 32'h00000009);
      rchk(timing_unit_pkg::WD_COUNT_OFS, 32'hFFFFFFFF, 32'h00000005);
      chk({31'h00000000, irq}, 32'h00000001);
      wr(timing_unit_pkg::IRQ_OFS, 32'h0000000F);
      rchk(timing_unit_pkg::IRQ_OFS, 32'h0000000F, 32'h00000000);
      chk({31'h00000000, irq}, 32'h00000000);
      // The millisecond base must still be running where the microsecond base expired.
      wr(timing_unit_pkg::WD_CTRL_OFS, 32'h00000003);
      cmd(32'h00000001);
      repeat (300) @(posedge pclk);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000003, 32'h00000001);
      cmd(32'h00000002);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000001, 32'h00000000);
      // General timer restarts after each run down.
      wr(timing_unit_pkg::GT_RELOAD_OFS, 32'h00000002);
      wr(timing_unit_pkg::GT_CTRL_OFS, 32'h00000008);
      cmd(32'h00000008);
      repeat (150) @(posedge pclk);
      rchk(timing_unit_pkg::IRQ_OFS, 32'h0000000F, 32'h00000002);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000004, 32'h00000004);
      rchk(timing_unit_pkg::GT_COUNT_OFS, 32'hFFFFF000, 32'h00000000);
      cmd(32'h00000010);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000004, 32'h00000000);
      cmd(32'h00000020);
      rchk(timing_unit_pkg::GT_COUNT_OFS, 32'hFFFFFFFF, 32'h00000002);
      wr(timing_unit_pkg::IRQ_OFS, 32'h00000002);
      // Event counter, up mode on rising edges with reload 3.
      wr(timing_unit_pkg::EC_RELOAD_OFS, 32'h00000003);
      wr(timing_unit_pkg::EC_CTRL_OFS, 32'h00000009);
      cmd(32'h00000040);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000000);
      tog(4);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000002);
      tog(2);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000000);
      rchk(timing_unit_pkg::IRQ_OFS, 32'h0000000F, 32'h00000004);
      chk({31'h00000000, irq}, 32'h00000001);
      wr(timing_unit_pkg::IRQ_OFS, 32'h00000004);
      // Down mode on both edges, interrupt disabled.
      wr(timing_unit_pkg::EC_CTRL_OFS, 32'h00000007);
      cmd(32'h00000040);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000003);
      tog(1);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000002);
      rchk(timing_unit_pkg::STATUS_OFS, 32'h00000028, 32'h00000028);
      cmd(32'h00000200);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000003);
      cmd(32'h00000100);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000000);
      tog(1);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000003);
      // The wrap is still flagged in the interrupt register; only the line is masked.
      rchk(timing_unit_pkg::IRQ_OFS, 32'h0000000F, 32'h00000004);
      chk({31'h00000000, irq}, 32'h00000000);
      wr(timing_unit_pkg::IRQ_OFS, 32'h00000004);
      cmd(32'h00000080);
      tog(1);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000003);
      // Falling edges only: the input is high here, so a fall then a rise gives one step.
      wr(timing_unit_pkg::EC_CTRL_OFS, 32'h00000006);
      cmd(32'h00000040);
      tog(2);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000002);
      // Up mode on rising edges from a high input: a fall then a rise gives one step,
      // and the trigger then returns the count to zero.
      wr(timing_unit_pkg::EC_CTRL_OFS, 32'h00000001);
      cmd(32'h00000040);
      tog(2);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000001);
      cmd(32'h00000200);
      rchk(timing_unit_pkg::EC_COUNT_OFS, 32'hFFFFFFFF, 32'h00000000);
      summarize();
   end
endmodule // timing_unit_bench
